// ==== core/unit_fault_monitor.v ====
// built-in test monitor: board polling, one second recheck, alarms, loopback gate
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "unit_fault_monitor_defines.vh"
// Function
// R1: poll each board in turn, check signals
// R2: boards report status on sixteen bit bus
// R3: missing signal starts one second recheck delay
// R4: persistent fault raises summary error flag
// R5: flag drives major and/or summary alarm
// R6: light defective board and panel indicators
// R7: own indicator lit only for external faults
// R8: summary alarm breaks loopback, inserts zeros
// R9: supply fault lights power and summary indicators
// R10: telemetry subchannel returned through monitored gate
// R11: delay counted on internal clock; flag clears
module unit_fault_monitor #(
  parameter RECHECK_CYC = `UFM_RECHECK_CYC
) (
  input  wire                           sys_clk_i,
  input  wire                           arst_n_i,
  input  wire                           psel_i,
  input  wire                           penable_i,
  input  wire                           pwrite_i,
  input  wire [11:0]                    paddr_i,
  input  wire [31:0]                    pwdata_i,
  output reg  [31:0]                    prdata_o,
  output wire                           pready_o,
  output wire                           pslverr_o,
  output reg  [`UFM_BOARD_W-1:0]        board_addr_o,
  input  wire [`UFM_BUS_W-1:0]          status_bus_i,
  input  wire                           supply_fault_i,
  input  wire                           telemetry_subchannel_i,
  output wire                           telemetry_subchannel_o,
  output wire                           major_alarm_o,
  output wire                           summary_alarm_out_o,
  output wire [`UFM_NUM_BOARDS-1:0]     board_led_o,
  output wire                           panel_summary_led_o,
  output wire                           monitor_led_o,
  output wire                           power_tol_led_o,
  output wire                           irq_o
);

  localparam S_SETTLE  = 4'b0001;
  localparam S_CHECK   = 4'b0010;
  localparam S_WAIT    = 4'b0100;
  localparam S_RECHECK = 4'b1000;
  localparam NB = `UFM_NUM_BOARDS;

  // status bus and supply fault come from other boards: three-stage sync;
  // a value is taken only once the last two stages agree, so a bus that
  // is still changing between boards is never latched half-way
  reg [`UFM_BUS_W-1:0] bus_s1_ff;
  reg [`UFM_BUS_W-1:0] bus_s2_ff;
  reg [`UFM_BUS_W-1:0] bus_s3_ff;
  reg [`UFM_BUS_W-1:0] bus_ok_ff;
  reg [2:0]            pwr_sync_ff;
  reg                  pwr_ok_ff;

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_s1_ff <= {`UFM_BUS_W{1'b0}};
      bus_s2_ff <= {`UFM_BUS_W{1'b0}};
      bus_s3_ff <= {`UFM_BUS_W{1'b0}};
      bus_ok_ff <= {`UFM_BUS_W{1'b0}};
    end else begin
      bus_s1_ff <= status_bus_i;  // see R2
      bus_s2_ff <= bus_s1_ff;
      bus_s3_ff <= bus_s2_ff;
      if (bus_s2_ff == bus_s3_ff) begin
        bus_ok_ff <= bus_s3_ff;
      end
    end
  end

  // supply monitor: same filter, one bit wide
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_sync_ff <= 3'b000;
      pwr_ok_ff   <= 1'b0;
    end else begin
      pwr_sync_ff <= {pwr_sync_ff[1:0], supply_fault_i};
      if (pwr_sync_ff[1] == pwr_sync_ff[2]) begin
        pwr_ok_ff <= pwr_sync_ff[2];
      end
    end
  end

  // registers
  reg [1:0]            ctrl_ff;
  reg [`UFM_IRQ_W-1:0] irq_stat_ff;
  reg [`UFM_IRQ_W-1:0] irq_mask_ff;
  reg [`UFM_BUS_W-1:0] expect_ff [0:NB-1];
  reg [1:0]            almsel_ff [0:NB-1];
  reg [`UFM_BUS_W-1:0] extsel_ff [0:NB-1];
  reg [NB-1:0]         fault_map_ff;
  reg [NB-1:0]         ext_map_ff;
  reg [NB-1:0]         major_map_ff;
  reg [NB-1:0]         sa_map_ff;
  reg [`UFM_BUS_W-1:0] synd_ff;

  // each table holds one word per board in a 32-byte window
  localparam [11:0] EXPECT_BASE = `UFM_ADDR_EXPECT0;
  localparam [11:0] ALMSEL_BASE = `UFM_ADDR_ALMSEL0;
  localparam [11:0] EXTSEL_BASE = `UFM_ADDR_EXTSEL0;

  wire       wr_en         = psel_i & penable_i & pwrite_i;
  wire [2:0] idx           = paddr_i[4:2];
  wire       sel_ctrl      = (paddr_i == `UFM_ADDR_CTRL);
  wire       sel_status    = (paddr_i == `UFM_ADDR_STATUS);
  wire       sel_irq_stat  = (paddr_i == `UFM_ADDR_IRQ_STAT);
  wire       sel_irq_mask  = (paddr_i == `UFM_ADDR_IRQ_MASK);
  wire       sel_fault_map = (paddr_i == `UFM_ADDR_FAULT_MAP);
  wire       sel_synd      = (paddr_i == `UFM_ADDR_SYND);
  wire       in_expect     = (paddr_i[11:5] == EXPECT_BASE[11:5]);
  wire       in_almsel     = (paddr_i[11:5] == ALMSEL_BASE[11:5]);
  wire       in_extsel     = (paddr_i[11:5] == EXTSEL_BASE[11:5]);
  wire       wr_ctrl       = wr_en & sel_ctrl;
  wire       wr_irq_stat   = wr_en & sel_irq_stat;
  wire       wr_irq_mask   = wr_en & sel_irq_mask;
  wire       wr_expect     = wr_en & in_expect;
  wire       wr_almsel     = wr_en & in_almsel;
  wire       wr_extsel     = wr_en & in_extsel;
  reg        addr_hit;

  // scanning engine
  reg [3:0]               state_ff;
  reg [31:0]              cnt_ff;
  reg [`UFM_BUS_W-1:0]    miss_ff;
  reg                     clear_evt_ff;
  reg                     fault_evt_ff;

  // last count of each timed phase, cut to the counter width
  localparam [31:0] SETTLE_LAST  = `UFM_SETTLE_CYC - 1;
  localparam [31:0] RECHECK_LAST = RECHECK_CYC - 1;
  wire settle_done = (cnt_ff == SETTLE_LAST);
  wire wait_done   = (cnt_ff == RECHECK_LAST);

  // settings of the board now on the bus
  wire [`UFM_BUS_W-1:0] cur_expect = expect_ff[board_addr_o];
  wire [`UFM_BUS_W-1:0] cur_extsel = extsel_ff[board_addr_o];
  wire [1:0]            cur_almsel = almsel_ff[board_addr_o];
  wire [`UFM_BUS_W-1:0] missing    = cur_expect & ~bus_ok_ff;  // see R1
  wire                  fault_now  = |missing;
  wire                  is_ext     = |(missing & cur_extsel);

  // scan engine: settle, check, then step on or wait and recheck

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff     <= S_SETTLE;
      cnt_ff       <= 32'h0000_0000;
      board_addr_o <= {`UFM_BOARD_W{1'b0}};
      fault_map_ff <= {NB{1'b0}};
      ext_map_ff   <= {NB{1'b0}};
      major_map_ff <= {NB{1'b0}};
      sa_map_ff    <= {NB{1'b0}};
      synd_ff      <= {`UFM_BUS_W{1'b0}};
      miss_ff      <= {`UFM_BUS_W{1'b0}};
      fault_evt_ff <= 1'b0;
      clear_evt_ff <= 1'b0;
    end else begin
      fault_evt_ff <= 1'b0;
      clear_evt_ff <= 1'b0;
      case (state_ff)
        S_SETTLE: begin
          // let the newly addressed board drive the bus through the sync
          if (!ctrl_ff[`UFM_CTRL_EN]) begin
            cnt_ff <= 32'h0000_0000;
          end else if (settle_done) begin
            cnt_ff   <= 32'h0000_0000;
            state_ff <= S_CHECK;
          end else begin
            cnt_ff <= cnt_ff + 32'h0000_0001;
          end
        end
        S_CHECK: begin
          // a clean board drops its flags at once and the scan moves on
          if (fault_now) begin
            miss_ff  <= missing;
            state_ff <= S_WAIT;  // see R3
          end else begin
            if (fault_map_ff[board_addr_o])
              clear_evt_ff <= 1'b1;
            fault_map_ff[board_addr_o] <= 1'b0;  // see R11
            ext_map_ff[board_addr_o]   <= 1'b0;
            major_map_ff[board_addr_o] <= 1'b0;
            sa_map_ff[board_addr_o]    <= 1'b0;
            board_addr_o <= board_addr_o + 1'b1;  // see R1
            state_ff     <= S_SETTLE;
          end
        end
        S_WAIT: begin
          // one second counted on the internal timing clock
          if (wait_done) begin  // see R11
            cnt_ff   <= 32'h0000_0000;
            state_ff <= S_RECHECK;
          end else begin
            cnt_ff <= cnt_ff + 32'h0000_0001;
          end
        end
        default: begin
          // recheck: a signal still missing now is a persistent fault
          if (fault_now) begin
            if (!fault_map_ff[board_addr_o])
              fault_evt_ff <= 1'b1;
            fault_map_ff[board_addr_o] <= 1'b1;  // see R4
            ext_map_ff[board_addr_o]   <= is_ext;  // see R7
            major_map_ff[board_addr_o] <= cur_almsel[0];  // see R5
            sa_map_ff[board_addr_o]    <= cur_almsel[1];  // see R5
            synd_ff <= missing;
          end else begin
            fault_map_ff[board_addr_o] <= 1'b0;  // see R4
            ext_map_ff[board_addr_o]   <= 1'b0;
            major_map_ff[board_addr_o] <= 1'b0;
            sa_map_ff[board_addr_o]    <= 1'b0;
          end
          board_addr_o <= board_addr_o + 1'b1;
          state_ff     <= S_SETTLE;
        end
      endcase
    end
  end

  wire summary_flag = |fault_map_ff;

  // alarm contacts and indicators are driven from flip-flops so that the
  // contacts never see a glitch while the flag maps are being updated
  reg                  major_alarm_ff;
  reg                  summary_alarm_ff;
  reg [NB-1:0]         board_led_ff;
  reg                  panel_led_ff;
  reg                  monitor_led_ff;
  reg                  power_led_ff;
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      major_alarm_ff   <= 1'b0;
      summary_alarm_ff <= 1'b0;
      board_led_ff     <= {NB{1'b0}};
      panel_led_ff     <= 1'b0;
      monitor_led_ff   <= 1'b0;
      power_led_ff     <= 1'b0;
    end else begin
      major_alarm_ff   <= |major_map_ff;  // see R5
      summary_alarm_ff <= |sa_map_ff;  // see R5
      board_led_ff     <= fault_map_ff & ~ext_map_ff;  // see R6
      panel_led_ff     <= summary_flag | pwr_ok_ff;  // see R6 see R9
      monitor_led_ff   <= |ext_map_ff;  // see R7
      power_led_ff     <= pwr_ok_ff;  // see R9
    end
  end

  assign major_alarm_o          = major_alarm_ff;
  assign summary_alarm_out_o    = summary_alarm_ff;
  assign board_led_o            = board_led_ff;
  assign panel_summary_led_o    = panel_led_ff;
  assign monitor_led_o          = monitor_led_ff;
  assign power_tol_led_o        = power_led_ff;
  // loopback gate: open from reset and switched by software, closed with zeros on summary alarm
  assign telemetry_subchannel_o = telemetry_subchannel_i & ctrl_ff[`UFM_CTRL_LOOP_EN]
                                  & ~summary_alarm_ff;  // see R8 see R10

  // interrupt status: an event in the same cycle as its clear wins, so no
  // event is lost to a late acknowledge
  reg                   pwr_prev_ff;
  wire [`UFM_IRQ_W-1:0] irq_set = {pwr_ok_ff & ~pwr_prev_ff, clear_evt_ff, fault_evt_ff};
  wire [`UFM_IRQ_W-1:0] irq_clr = wr_irq_stat ? pwdata_i[`UFM_IRQ_W-1:0] : {`UFM_IRQ_W{1'b0}};
  assign irq_o = |(irq_stat_ff & irq_mask_ff);

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_prev_ff <= 1'b0;
      irq_stat_ff <= {`UFM_IRQ_W{1'b0}};
    end else begin
      pwr_prev_ff <= pwr_ok_ff;
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
    end
  end

  // control, mask and per-board tables
  integer i;
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_ff     <= `UFM_CTRL_RST;
      irq_mask_ff <= {`UFM_IRQ_W{1'b0}};
      for (i = 0; i < NB; i = i + 1) begin
        expect_ff[i] <= `UFM_EXPECT_RST;
        almsel_ff[i] <= `UFM_ALMSEL_RST;
        extsel_ff[i] <= {`UFM_BUS_W{1'b0}};
      end
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= pwdata_i[1:0];
      end else if (wr_irq_mask) begin
        irq_mask_ff <= pwdata_i[`UFM_IRQ_W-1:0];
      end else if (wr_expect) begin
        expect_ff[idx] <= pwdata_i[`UFM_BUS_W-1:0];
      end else if (wr_almsel) begin
        almsel_ff[idx] <= pwdata_i[1:0];
      end else if (wr_extsel) begin
        extsel_ff[idx] <= pwdata_i[`UFM_BUS_W-1:0];
      end
    end
  end

  // read mux, zero-wait answer: data stands while the address is held
  always @* begin
    prdata_o = 32'h0000_0000;
    addr_hit = 1'b1;
    if (sel_ctrl) begin
      prdata_o[1:0] = ctrl_ff;
    end else if (sel_status) begin
      prdata_o[`UFM_BOARD_W-1:0] = board_addr_o;
      prdata_o[11:8]             = state_ff;
      prdata_o[16]               = summary_flag;
      prdata_o[17]               = pwr_ok_ff;
    end else if (sel_irq_stat) begin
      prdata_o[`UFM_IRQ_W-1:0] = irq_stat_ff;
    end else if (sel_irq_mask) begin
      prdata_o[`UFM_IRQ_W-1:0] = irq_mask_ff;
    end else if (sel_fault_map) begin
      prdata_o[7:0]   = fault_map_ff;
      prdata_o[15:8]  = major_map_ff;
      prdata_o[23:16] = sa_map_ff;
      prdata_o[31:24] = ext_map_ff;
    end else if (sel_synd) begin
      prdata_o[`UFM_BUS_W-1:0] = synd_ff;
    end else if (in_expect) begin
      prdata_o[`UFM_BUS_W-1:0] = expect_ff[idx];
    end else if (in_almsel) begin
      prdata_o[1:0] = almsel_ff[idx];
    end else if (in_extsel) begin
      prdata_o[`UFM_BUS_W-1:0] = extsel_ff[idx];
    end else begin
      addr_hit = 1'b0;
    end
  end

  // unmapped offsets answer with an error; writes there are dropped
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~addr_hit;

endmodule // unit_fault_monitor

// ==== core/unit_fault_monitor_defines.vh ====
// constants for the built-in test monitor: register map, fields, timing
`ifndef UNIT_FAULT_MONITOR_DEFINES_VH
`define UNIT_FAULT_MONITOR_DEFINES_VH
`define UFM_BUS_W          16
`define UFM_BOARD_W        3
`define UFM_NUM_BOARDS     8
`define UFM_SETTLE_CYC     4
`define UFM_RECHECK_MS     1000
`define UFM_CLK_KHZ        100000
`define UFM_RECHECK_CYC    (`UFM_RECHECK_MS * `UFM_CLK_KHZ)
`define UFM_ADDR_CTRL      12'h000
`define UFM_ADDR_STATUS    12'h004
`define UFM_ADDR_IRQ_STAT  12'h008
`define UFM_ADDR_IRQ_MASK  12'h00c
`define UFM_ADDR_FAULT_MAP 12'h010
`define UFM_ADDR_SYND      12'h014
`define UFM_ADDR_EXPECT0   12'h020
`define UFM_ADDR_ALMSEL0   12'h040
`define UFM_ADDR_EXTSEL0   12'h060
`define UFM_CTRL_EN        0
`define UFM_CTRL_LOOP_EN   1
`define UFM_CTRL_RST       2'h3
`define UFM_ALMSEL_RST     2'h3
`define UFM_EXPECT_RST     16'hffff
`define UFM_IRQ_W          3
`define UFM_IRQ_FAULT      0
`define UFM_IRQ_CLEAR      1
`define UFM_IRQ_POWER      2
`endif

// ==== testbench/board_model.sv ====
// far-side boards answering the poll on the status bus
`timescale 1ns/1ps
module board_model (
  input  wire [2:0]  board_addr_i,
  input  wire [2:0]  bad_board_i,
  input  wire [15:0] miss_i,
  output wire [15:0] status_bus_o
);
  assign status_bus_o = (board_addr_i == bad_board_i) ? ~miss_i : 16'hffff;
endmodule // board_model

// ==== testbench/unit_fault_monitor_monitor.sv ====
// port checker for the unit fault monitor
`timescale 1ns/1ps
module unit_fault_monitor_monitor #(
  parameter RECHECK_CYC = 20
) (
  input wire       sys_clk_i,
  input wire       arst_n_i,
  input wire [2:0] board_addr_o,
  input wire       telemetry_subchannel_o,
  input wire       major_alarm_o,
  input wire       summary_alarm_out_o,
  input wire [7:0] board_led_o,
  input wire       panel_summary_led_o,
  input wire       monitor_led_o,
  input wire       power_tol_led_o
);
  reg [31:0] same_ff;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  // cycles the polled address has stood unchanged
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) same_ff <= 32'h0;
    else if ($changed(board_addr_o)) same_ff <= 32'h0;
    else same_ff <= same_ff + 32'h1;
  end
  AST_ADDR_STEP:
    assert property ($changed(board_addr_o) |-> board_addr_o == $past(board_addr_o) + 3'h1) else $error("address skipped");
  AST_ADDR_HOLD:
    assert property ($changed(board_addr_o) |=> $stable(board_addr_o) [*4]) else $error("address too short");
  AST_DELAY:
    assert property ($rose(|board_led_o || monitor_led_o) |-> $past(same_ff) >= RECHECK_CYC) else $error("no recheck delay");
  AST_MAJOR_PANEL:
    assert property (major_alarm_o |-> panel_summary_led_o) else $error("major without flag");
  AST_SA_PANEL:
    assert property (summary_alarm_out_o |-> panel_summary_led_o) else $error("summary without flag");
  AST_BOARD_PANEL:
    assert property (|board_led_o |-> panel_summary_led_o) else $error("board led alone");
  AST_MON_PANEL:
    assert property (monitor_led_o |-> panel_summary_led_o) else $error("monitor led alone");
  AST_LOOP_ZERO:
    assert property (summary_alarm_out_o |-> !telemetry_subchannel_o) else $error("loop not broken");
  AST_PWR_PANEL:
    assert property (power_tol_led_o |-> panel_summary_led_o) else $error("power led alone");
endmodule // unit_fault_monitor_monitor
bind unit_fault_monitor unit_fault_monitor_monitor #(.RECHECK_CYC(RECHECK_CYC)) mon (
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .board_addr_o(board_addr_o),
  .telemetry_subchannel_o(telemetry_subchannel_o), .major_alarm_o(major_alarm_o),
  .summary_alarm_out_o(summary_alarm_out_o), .board_led_o(board_led_o),
  .panel_summary_led_o(panel_summary_led_o), .monitor_led_o(monitor_led_o),
  .power_tol_led_o(power_tol_led_o));

// ==== testbench/unit_fault_monitor_tb.sv ====
// self-checking bench for the unit fault monitor
`timescale 1ns/1ps
module unit_fault_monitor_tb;
  reg         clk, rst_n, sel, en, wr, pwr, ti, err;
  reg  [11:0] pa;
  reg  [31:0] wd, rd, r, rt;
  reg  [2:0]  bad, b;
  reg  [15:0] miss;
  wire [31:0] prd;
  wire        rdy, serr, to, maj, sa, pan, mon, pl, irq;
  wire [2:0]  ba;
  wire [15:0] bus;
  wire [7:0]  led;
  integer     err_count, comparisons, cyc, i, k;
  unit_fault_monitor #(.RECHECK_CYC(20)) uut (.sys_clk_i(clk), .arst_n_i(rst_n), .psel_i(sel),
    .penable_i(en), .pwrite_i(wr), .paddr_i(pa), .pwdata_i(wd), .prdata_o(prd), .pready_o(rdy),
    .pslverr_o(serr), .board_addr_o(ba), .status_bus_i(bus), .supply_fault_i(pwr),
    .telemetry_subchannel_i(ti), .telemetry_subchannel_o(to), .major_alarm_o(maj),
    .summary_alarm_out_o(sa), .board_led_o(led), .panel_summary_led_o(pan),
    .monitor_led_o(mon), .power_tol_led_o(pl), .irq_o(irq));
  board_model far (.board_addr_i(ba), .bad_board_i(bad), .miss_i(miss), .status_bus_o(bus));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    rt = $urandom;
    ti <= rt[0];
    if (cyc == 20000) begin
      err_count = err_count + 1;
      end_sim;
    end
  end
  task settle;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk);
      {sel, en, wr, pa, wd} <= {2'b10, w, a, d};
      @(posedge clk);
      en <= 1'b1;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      rd = prd;
      err = serr;
      {sel, en} <= 2'b00;
    end
  endtask
  task end_sim;
    begin
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    {sel, en, wr, pa, wd, pwr, ti, bad, miss, err_count, comparisons, cyc} = 0;
    rst_n = 1'b0;
    r = $urandom(16);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h040, 0);
    chk(rd, 32'h3);
    apb(1'b0, 12'h0fc, 0);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("registers done");
    apb(1'b1, 12'h00c, 1);
    for (k = 1; k < 4; k = k + 1) begin
      r = $urandom;
      b = r[2:0];
      apb(1'b1, 12'h040 + {b, 2'b00}, k);
      bad <= b;
      miss <= r[31:16] | 16'h1;
      for (i = 0; i < 300 && led[b] !== 1'b1; i = i + 1) settle;
      chk(led, 32'h1 << b);
      chk({maj, sa, pan, irq}, {k[0], k[1], 2'b11});
      chk(to, ti & ~k[1]);
      miss <= 16'h0;
      for (i = 0; i < 300 && pan !== 1'b0; i = i + 1) settle;
      chk(led, 0);
      apb(1'b1, 12'h008, 7);
      settle;
      chk(irq, 0);
    end
    $display("persistent faults done");
    bad <= 3'h5;
    miss <= 16'h0100;
    for (i = 0; i < 300 && ba !== 3'h5; i = i + 1) settle;
    repeat (12) settle;
    miss <= 16'h0;
    repeat (30) settle;
    chk({pan, led}, 0);
    $display("transient fault done");
    apb(1'b1, 12'h060 + {b, 2'b00}, 32'hffff);
    bad <= b;
    miss <= 16'h0002;
    for (i = 0; i < 300 && mon !== 1'b1; i = i + 1) settle;
    chk({mon, led}, 32'h100);
    miss <= 16'h0;
    for (i = 0; i < 300 && pan !== 1'b0; i = i + 1) settle;
    apb(1'b1, 12'h060 + {b, 2'b00}, 0);
    apb(1'b1, 12'h008, 7);
    $display("external fault done");
    pwr <= 1'b1;
    repeat (8) settle;
    chk({pl, pan, irq}, 3'b110);
    apb(1'b0, 12'h008, 0);
    chk(rd[2], 1);
    pwr <= 1'b0;
    apb(1'b1, 12'h000, 1);
    settle;
    chk(to, 0);
    apb(1'b1, 12'h000, 3);
    settle;
    chk(to, ti);
    $display("power and loop done");
    end_sim;
  end
endmodule // unit_fault_monitor_tb
